// ==== design/dsfi_port.sv ====
// serial frame input port: link-side shifter, toggle crossing, word fifo
`timescale 1ns/10ps
// ==========================================================
// notes and module
// Notes on behaviour
// - shift register is exactly sixteen bits
// - data sampled on serial clock falling edge
// - input buffers off after each completed write
// - low frame select opens sixteen-edge frame
// - early frame select rise aborts, discards
// - reset holds zero word until valid frame is taken by a ready consumer
module dsfi_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clock,
  input wire logic frame_n,
  input wire logic serial_data,
  output logic [15:0] word,
  output logic word_valid,
  input wire logic word_ready,
  output logic word_loaded,
  output logic buffers_on,
  output logic frame_dropped,
  output logic [15:0] dac_word
);
  // ==========================================================
  // link domain: bit counter
  // frame_n high clears the bit counter and shift register at once, so an aborted frame is
  // forgotten without any further link edge while the host parks its clock
  logic [4:0] bit_count;
  wire [4:0] next_bit_count = bit_count + 5'h01;
  wire frame_full = (bit_count == dsfi_pkg::bits_per_frame);
  wire last_edge = (bit_count == dsfi_pkg::bits_per_frame - 5'h01);
  wire shift_enable = !frame_full;
  always_ff @(negedge link_clock or posedge frame_n) begin
    if (frame_n) begin
      bit_count <= '0;
    end else if (shift_enable) begin
      bit_count <= next_bit_count;
    end
  end
  // ==========================================================
  // link domain: input shift register
  logic [15:0] shift;
  wire [15:0] next_shift;
  // the first bit sent ends up in the top bit after sixteen edges
  assign next_shift[0] = serial_data;
  for (genvar b = 1; b < 16; b = b + 1) begin : g_shift
    assign next_shift[b] = shift[b - 1];
  end
  always_ff @(negedge link_clock or posedge frame_n) begin
    if (frame_n) begin
      shift <= dsfi_pkg::word_reset;
    end else if (shift_enable) begin
      shift <= next_shift;
    end
  end
  // ==========================================================
  // link domain: completed word and its toggle
  // both change on the sixteenth edge only and then stand for the whole
  // crossing; the system reset clears them while the link clock is parked,
  // so the toggle agrees with the synchroniser and no false word follows
  logic [15:0] held_word;
  logic done_toggle;
  wire word_complete = !frame_n && last_edge;
  wire next_toggle = ~done_toggle;
  always_ff @(negedge link_clock or posedge rst) begin
    if (rst) begin
      held_word <= dsfi_pkg::word_reset;
    end else if (word_complete) begin
      held_word <= next_shift;
    end
  end
  always_ff @(negedge link_clock or posedge rst) begin
    if (rst) begin
      done_toggle <= 1'b0;
    end else if (word_complete) begin
      done_toggle <= next_toggle;
    end
  end
  // ==========================================================
  // crossing into the system clock
  logic toggle_sync;
  logic toggle_seen;
  logic frame_sync;
  logic frame_seen;
  dsfi_sync u_sync_toggle (
    .clock(clock),
    .rst(rst),
    .level_in(done_toggle),
    .level_out(toggle_sync)
  );
  // frame select is carried active high so that reset reads as no frame
  dsfi_sync u_sync_frame (
    .clock(clock),
    .rst(rst),
    .level_in(~frame_n),
    .level_out(frame_sync)
  );
  always_ff @(posedge clock) begin
    if (rst) begin
      toggle_seen <= 1'b0;
    end else begin
      toggle_seen <= toggle_sync;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_seen <= 1'b0;
    end else begin
      frame_seen <= frame_sync;
    end
  end
  // the held word changes on the same link edge as its toggle, which then
  // crosses two synchroniser stages, so it is stable when the event shows here
  wire word_event = toggle_sync ^ toggle_seen;
  wire frame_start = frame_sync && !frame_seen;
  // ==========================================================
  // frame tracking for the input buffers
  typedef enum logic [1:0] {st_idle, st_open, st_done} dsfi_frame_t;
  dsfi_frame_t state;
  dsfi_frame_t next_state;
  // a word and the end of its frame may be seen in one cycle; the word
  // wins and the level of frame select still brings the machine home
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (frame_start) begin
          next_state = st_open;
        end
      end
      st_open: begin
        if (word_event) begin
          next_state = st_done;
        end else if (!frame_sync) begin
          next_state = st_idle;
        end
      end
      st_done: begin
        if (!frame_sync) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end
  // the buffers sleep as soon as the word is in, not when frame select
  // returns, so a host that lingers in the frame costs no power
  wire next_buffers_on = (next_state == st_open);
  // ==========================================================
  // captured word
  logic [15:0] captured;
  logic captured_valid;
  wire [15:0] next_captured = word_event ? held_word : captured;
  always_ff @(posedge clock) begin
    if (rst) begin
      captured <= dsfi_pkg::word_reset;
    end else begin
      captured <= next_captured;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      captured_valid <= 1'b0;
    end else begin
      captured_valid <= word_event;
    end
  end
  // ==========================================================
  // buffered word stream
  logic [15:0] fifo_data;
  logic fifo_valid;
  logic fifo_in_ready;
  // a word leaves the fifo only towards a ready consumer and at most every
  // other cycle, so each word_valid pulse carries a word of its own
  wire take = fifo_valid && word_ready && !word_valid;
  // a full fifo cannot stall the host; the word is dropped and flagged
  wire lost = captured_valid && !fifo_in_ready;
  dsfi_fifo #(
    .width(dsfi_pkg::word_width),
    .depth(dsfi_pkg::fifo_depth)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_data(captured),
    .in_valid(captured_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(take)
  );
  // ==========================================================
  // output registers
  wire [15:0] next_word = take ? fifo_data : word;
  wire [15:0] next_dac_word = take ? fifo_data : dac_word;
  wire next_word_valid = take;
  wire next_frame_dropped = lost;
  always_ff @(posedge clock) begin
    if (rst) begin
      word <= dsfi_pkg::word_reset;
    end else begin
      word <= next_word;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      word_valid <= 1'b0;
    end else begin
      word_valid <= next_word_valid;
    end
  end
  // the converter word reads zero from reset until a whole frame leaves the fifo towards a ready consumer
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_word <= dsfi_pkg::word_reset;
    end else begin
      dac_word <= next_dac_word;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      word_loaded <= 1'b0;
    end else begin
      word_loaded <= next_word_valid;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_dropped <= 1'b0;
    end else begin
      frame_dropped <= next_frame_dropped;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      buffers_on <= 1'b0;
    end else begin
      buffers_on <= next_buffers_on;
    end
  end
endmodule : dsfi_port

// ==== design/dsfi_pkg.sv ====
// package of constants for the dac serial frame input port
package dsfi_pkg;
  localparam int unsigned word_width = 16;
  localparam int unsigned bit_count_width = 5;
  localparam logic [4:0] bits_per_frame = 5'h10;
  localparam logic [15:0] word_reset = 16'h0000;
  localparam int unsigned fifo_depth = 4;
  localparam int unsigned sync_stages = 2;
  localparam int unsigned max_link_mhz = 30;
  localparam int unsigned clock_period_ns = 50;
endpackage : dsfi_pkg

// ==== design/dsfi_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/10ps
module dsfi_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic level_in,
  output logic level_out
);
  logic stage_a;
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_a <= 1'b0;
      level_out <= 1'b0;
    end else begin
      stage_a <= level_in;
      level_out <= stage_a;
    end
  end
endmodule : dsfi_sync

// ==== design/dsfi_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module dsfi_fifo #(
  parameter int unsigned width = 16,
  parameter int unsigned depth = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [width-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [width-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr;
  logic [aw-1:0] rd_ptr;
  logic [aw:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != (aw + 1)'(depth));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{aw{1'b0}}, push} - {{aw{1'b0}}, pop};
    end
  end
endmodule : dsfi_fifo

// ==== sim/dsfi_host.sv ====
// host serial master model for the frame input port
`timescale 1ns/10ps
module dsfi_host (
  output logic link_clock,
  output logic frame_n,
  output logic serial_data
);
  initial begin
    link_clock = 1'b1;
    frame_n = 1'b1;
    serial_data = 1'b0;
  end
  // 48 ns link period, clock parked high between frames
  task automatic send(input logic [15:0] w, input int n);
    #7 frame_n = 1'b0; // odd offset keeps link events off system clock rising edges
    for (int i = 15; i > 15 - n; i--) begin
      #12 serial_data = w[i[3:0]]; // msb first, settled before the fall
      #12 link_clock = 1'b0;
      #24 link_clock = 1'b1;
    end
    #12 frame_n = 1'b1; // rise ends the frame; it aborts only when n is below sixteen
    serial_data = ~serial_data;
    #120;
  endtask : send
endmodule : dsfi_host

// ==== sim/dsfi_port_props.sv ====
// concurrent checks on the frame input port
`timescale 1ns/10ps
module dsfi_port_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic frame_n,
  input wire logic [15:0] word,
  input wire logic word_valid,
  input wire logic word_loaded,
  input wire logic buffers_on,
  input wire logic frame_dropped,
  input wire logic [15:0] dac_word
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_load_pairs: assert property (word_loaded == word_valid)
    else $error("load pulse apart from valid");
  a_dac_follows: assert property (word_valid |-> dac_word == word)
    else $error("dac word differs from word");
  a_dac_holds: assert property (!word_valid |-> dac_word == $past(dac_word))
    else $error("dac word changed without valid");
  a_reset_zero: assert property (disable iff (1'b0) rst |=> dac_word == 16'h0000)
    else $error("dac word not zero after reset");
  // five samples cover the two-stage crossing plus the output register
  a_buffers_off: assert property (frame_n [*5] |-> !buffers_on)
    else $error("buffers on outside a frame");
  a_drop_single: assert property (frame_dropped |=> !frame_dropped)
    else $error("drop pulse too long");
  cover property (word_valid);
  cover property (frame_dropped);
  cover property ($fell(buffers_on));
endmodule : dsfi_port_props
bind dsfi_port dsfi_port_props props_u (.clock, .rst, .frame_n, .word, .word_valid,
  .word_loaded, .buffers_on, .frame_dropped, .dac_word);

// ==== sim/test_dsfi_port.sv ====
// self-checking bench for the frame input port
`timescale 1ns/10ps
module test_dsfi_port;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic word_ready = 1'b1;
  logic link_clock, frame_n, serial_data, word_valid, word_loaded, buffers_on, frame_dropped;
  logic [15:0] word, dac_word;
  logic [15:0] lfsr = 16'h003c;
  logic [15:0] exp_q[$];
  int err_count = 0, num_checks = 0, drops = 0, exp_drops = 0, cycles = 0, on_cycles = 0;
  always #25 clock = ~clock;
  dsfi_host host_u (.link_clock, .frame_n, .serial_data);
  dsfi_port dut_u (.clock, .rst, .link_clock, .frame_n, .serial_data, .word, .word_valid,
    .word_ready, .word_loaded, .buffers_on, .frame_dropped, .dac_word);
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : step
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // a full frame is queued unless four words already wait
  task automatic frame(input int n);
    lfsr = step(lfsr);
    if (n > 15 && exp_q.size() < 4) exp_q.push_back(lfsr);
    else if (n > 15) exp_drops++;
    host_u.send(lfsr, n);
    repeat (10) @(posedge clock);
    $display("frame of %0d bits done", n);
  endtask : frame
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
    if (frame_dropped) drops++;
    if (buffers_on) on_cycles++;
    if (word_valid) begin
      check("word", word, exp_q[0]);
      check("word_loaded", {15'h0000, word_loaded}, 16'h0001);
      check("dac_word", dac_word, exp_q[0]);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    check("dac_word", dac_word, 16'h0000);
    frame(16);
    check("buffers_seen", 16'(on_cycles > 0), 16'h0001);
    frame(15);
    frame(16);
    frame(20);
    check("buffers_on", {15'h0000, buffers_on}, 16'h0000);
    word_ready <= 1'b0;
    repeat (5) frame(16);
    word_ready <= 1'b1;
    // let the four waiting words drain before the model judges the next frame
    repeat (20) @(posedge clock);
    frame(16);
    check("drops", drops[15:0], exp_drops[15:0]);
    check("left", 16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule : test_dsfi_port
